// >>> src/spm_serial_port_mode_control.sv
// Mode word registers, command gating and character framing for two serial ports.
// Assumes upstream logic delivers characters and decoded commands on sys_clk.
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module spm_serial_port_mode_control #(
  parameter int BAUD_DIV = spm_pkg::BAUD_DIV_RST
) (
  // Clock and reset.
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // AXI4-Lite register slave.
  input  wire logic [4:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [4:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Outgoing characters, one stream per port.
  input  wire logic [1:0]        txValid,
  input  wire logic [1:0][7:0]   txData,
  input  wire logic [1:0]        txUnsol,
  input  wire logic [1:0]        txEcho,
  output logic [1:0]             txReady,
  // Received characters from the port receivers.
  input  wire logic [1:0]        rxValid,
  input  wire logic [1:0][7:0]   rxData,
  input  wire logic [1:0]        rxRoom,
  output logic [1:0]             rxLine,
  // Decoded commands.
  input  wire logic [1:0]        cmdValid,
  input  wire logic [1:0]        cmdHelp,
  input  wire logic [1:0]        cmdPass,
  input  wire logic [1:0][15:0]  cmdId,
  output logic [1:0]             cmdAccept,
  output logic [1:0]             cmdReject,
  // Line pins: A is connector pin 2, B is pin 3.
  input  wire logic [1:0]        lineA_i,
  output logic [1:0]             lineA_o,
  output logic [1:0]             lineA_oe,
  input  wire logic [1:0]        lineB_i,
  output logic [1:0]             lineB_o,
  output logic [1:0]             lineB_oe,
  input  wire logic [1:0]        cts_i,
  output logic [1:0]             rts_o,
  output logic [1:0]             dsr_o,
  // Board straps and role switch.
  input  wire logic              roleDte,
  input  wire logic              boardSel6,
  input  wire logic              terminationStrap,
  // Configuration seen by the protocol firmware.
  output logic [1:0]             modemInitReq,
  output logic [1:0]             cfgAltProto,
  output logic [1:0]             cfgParityFix,
  output logic [1:0]             cfgFifo,
  output logic [1:0]             cfgPrompt,
  output logic                   rs485Active,
  output logic                   termActive
);
  import spm_pkg::*;

  logic [MODE_W-1:0] modeQ [2];
  logic [15:0]       idQ;
  logic [8:0]        syncA_q;
  logic [8:0]        syncB_q;
  logic [1:0]        aS;
  logic [1:0]        bS;
  logic [1:0]        ctsS;
  logic              dteS;
  logic              sel6S;
  logic              termS;
  logic [1:0]        rs485;
  logic [1:0]        cmdOk;
  logic [1:0]        cmdBad;
  logic [1:0]        unlocked_q;
  logic [1:0]        started;

  // Every pin and strap passes two flops before any logic reads it.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else begin
      syncA_q <= {terminationStrap, boardSel6, roleDte, cts_i, lineB_i, lineA_i};
      syncB_q <= syncA_q;
    end
  end
  assign aS = syncB_q[1:0];
  assign bS = syncB_q[3:2];
  assign ctsS = syncB_q[5:4];
  assign dteS = syncB_q[6];
  assign sel6S = syncB_q[7];
  assign termS = syncB_q[8];

  // Only the second port can run RS-485, and only with the selector on.
  assign rs485[0] = 1'b0;
  assign rs485[1] = modeQ[1][B_RS485] & sel6S;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rs485Active <= 1'b0;
      termActive <= 1'b0;
    end else begin
      rs485Active <= rs485[1];
      termActive <= rs485[1] & termS;
    end
  end

  // Register slave. Address and data are held until both have arrived.
  logic        awHave_q;
  logic        wHave_q;
  logic [4:0]  awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        doWrite;
  logic [31:0] status;

  assign doWrite = awHave_q & wHave_q & ~s_axi_bvalid;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
    end else begin
      s_axi_awready <= ~awHave_q & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~wHave_q & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_q == OFS_MODE0 || awAddr_q == OFS_MODE1 ||
                        awAddr_q == OFS_ID) ? RESP_OK : RESP_SLV;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Each port's mode word is written only through its own address.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      modeQ[0] <= MODE_RST;
      modeQ[1] <= MODE_RST;
      idQ <= ID_RST;
    end else if (doWrite) begin
      for (int i = 0; i < 2; i++) begin
        if (awAddr_q == (i == 0 ? OFS_MODE0 : OFS_MODE1)) begin
          if (wStrb_q[0]) modeQ[i][7:0] <= wData_q[7:0];
          if (wStrb_q[1]) modeQ[i][12:8] <= wData_q[12:8];
        end
      end
      if (awAddr_q == OFS_ID) begin
        if (wStrb_q[0]) idQ[7:0] <= wData_q[7:0];
        if (wStrb_q[1]) idQ[15:8] <= wData_q[15:8];
      end
    end
  end

  assign status = {24'h000000, unlocked_q, started, termS, sel6S, rs485[1], dteS};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OK;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OK;
        case (s_axi_araddr)
          OFS_MODE0:  s_axi_rdata <= {19'h00000, modeQ[0]};
          OFS_MODE1:  s_axi_rdata <= {19'h00000, modeQ[1]};
          OFS_ID:     s_axi_rdata <= {16'h0000, idQ};
          OFS_STATUS: s_axi_rdata <= status;
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLV;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [MODE_W-1:0] m;
    logic              addressed;
    logic              xoff_q;
    logic              modemDone_q;
    logic              accept;
    logic              drop;
    spm_tx_t           st_q;
    logic [9:0]        shf_q;
    logic [3:0]        bitCnt_q;
    logic [15:0]       div_q;
    logic              txBit;
    logic              swap;

    assign m = modeQ[p];
    // RS-485 wins over multidrop addressing when both are set.
    assign addressed = ~m[B_MDROP] | rs485[p] | (cmdId[p] == idQ);
    assign cmdOk[p] = addressed & (~m[B_SECURE] | unlocked_q[p] |
                                   cmdHelp[p] | cmdPass[p]);
    assign cmdBad[p] = addressed & ~cmdOk[p];

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        unlocked_q[p] <= 1'b0;
        cmdAccept[p] <= 1'b0;
        cmdReject[p] <= 1'b0;
      end else begin
        cmdAccept[p] <= cmdValid[p] & cmdOk[p];
        cmdReject[p] <= cmdValid[p] & cmdBad[p];
        if (cmdValid[p] & cmdPass[p] & addressed) unlocked_q[p] <= 1'b1;
      end
    end

    // Unsolicited reports in quiet mode and echoes in computer mode are taken and discarded, never sent.
    assign drop = (m[B_QUIET] & txUnsol[p]) | (m[B_COMPUTER] & txEcho[p]);
    assign accept = txValid[p] & txReady[p];
    assign started[p] = accept & ~drop;

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        xoff_q <= 1'b0;
      end else if (~m[B_XONOFF]) begin
        xoff_q <= 1'b0;
      end else if (rxValid[p] && rxData[p] == CH_XOFF) begin
        xoff_q <= 1'b1;
      end else if (rxValid[p] && rxData[p] == CH_XON) begin
        xoff_q <= 1'b0;
      end
    end

    // Ready is withheld while paused, so a paused port also holds dropped output.
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        txReady[p] <= 1'b0;
      end else begin
        txReady[p] <= st_q == TX_IDLE && !accept && !xoff_q &&
                      (!m[B_HWHS] || ctsS[p] || rs485[p]);
      end
    end

    // Seven-bit framing replaces bit 7 with even parity; both frames are ten bits.
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        st_q <= TX_IDLE;
        shf_q <= '1;
        bitCnt_q <= '0;
        div_q <= '0;
      end else begin
        case (st_q)
          TX_IDLE: begin
            if (started[p]) begin
              st_q <= TX_SHIFT;
              shf_q <= {1'b1, m[B_E71] ? ^txData[p][6:0] : txData[p][7],
                        txData[p][6:0], 1'b0};
              bitCnt_q <= '0;
              div_q <= '0;
            end
          end
          TX_SHIFT: begin
            if (div_q == 16'(BAUD_DIV - 1)) begin
              div_q <= '0;
              shf_q <= {1'b1, shf_q[9:1]};
              bitCnt_q <= bitCnt_q + 4'h1;
              if (bitCnt_q == FRAME_BITS - 4'h1) st_q <= TX_IDLE;
            end else begin
              div_q <= div_q + 16'h0001;
            end
          end
          default: st_q <= TX_IDLE;
        endcase
      end
    end

    assign txBit = st_q == TX_SHIFT ? shf_q[0] : 1'b1;
    // Only the first port has the rear-panel role switch.
    assign swap = (p == 0) && dteS;

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        lineA_o[p] <= 1'b1;
        lineA_oe[p] <= 1'b0;
        lineB_o[p] <= 1'b1;
        lineB_oe[p] <= 1'b0;
        rxLine[p] <= 1'b1;
      end else if (rs485[p]) begin
        lineA_o[p] <= ~txBit;
        lineB_o[p] <= txBit;
        lineA_oe[p] <= st_q == TX_SHIFT;
        lineB_oe[p] <= st_q == TX_SHIFT;
        rxLine[p] <= bS[p];
      end else begin
        lineA_o[p] <= txBit;
        lineB_o[p] <= txBit;
        lineA_oe[p] <= ~swap;
        lineB_oe[p] <= swap;
        rxLine[p] <= swap ? aS[p] : bS[p];
      end
    end

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        rts_o[p] <= 1'b0;
        dsr_o[p] <= 1'b0;
        modemDone_q <= 1'b0;
        modemInitReq[p] <= 1'b0;
        cfgAltProto[p] <= 1'b0;
        cfgParityFix[p] <= 1'b0;
        cfgFifo[p] <= 1'b0;
        cfgPrompt[p] <= 1'b0;
      end else begin
        rts_o[p] <= ~m[B_HWHS] | rxRoom[p];
        dsr_o[p] <= m[B_MODEM];
        modemInitReq[p] <= m[B_MODEM] & ~modemDone_q;
        if (m[B_MODEM]) modemDone_q <= 1'b1;
        cfgAltProto[p] <= m[B_PROTO];
        cfgParityFix[p] <= m[B_ERRFIX];
        cfgFifo[p] <= m[B_FIFO];
        cfgPrompt[p] <= m[B_PROMPT];
      end
    end

    sequence sLockedCmd;
      cmdValid[p] && m[B_SECURE] && !unlocked_q[p] && !cmdHelp[p] &&
      !cmdPass[p] && addressed;
    endsequence
    sequence sFrameEnd;
      st_q == TX_SHIFT ##1 st_q == TX_IDLE;
    endsequence

    a_locked_reject: assert property (@(posedge sys_clk) disable iff (rst)
      sLockedCmd |=> cmdReject[p] && !cmdAccept[p])
      else $error("Locked port accepted a command.");
    a_quiet_drop: assert property (@(posedge sys_clk) disable iff (rst)
      accept && m[B_QUIET] && txUnsol[p] |=> st_q == TX_IDLE)
      else $error("Unsolicited output sent in quiet mode.");
    a_echo_drop: assert property (@(posedge sys_clk) disable iff (rst)
      accept && m[B_COMPUTER] && txEcho[p] |=> st_q == TX_IDLE)
      else $error("Echo sent in computer mode.");
    a_xoff_pause: assert property (@(posedge sys_clk) disable iff (rst)
      m[B_XONOFF] && rxValid[p] && rxData[p] == CH_XOFF ##1 m[B_XONOFF]
      |=> !txReady[p])
      else $error("Transmit ready while paused.");
    a_cts_pace: assert property (@(posedge sys_clk) disable iff (rst)
      m[B_HWHS] && !rs485[p] && !ctsS[p] |=> !txReady[p])
      else $error("Transmit ready without clear to send.");
    a_parity_bit: assert property (@(posedge sys_clk) disable iff (rst)
      started[p] && m[B_E71] |=> shf_q[8] == ^$past(txData[p][6:0]))
      else $error("Even parity bit wrong.");
    a_driver_release: assert property (@(posedge sys_clk) disable iff (rst)
      rs485[p] ##0 sFrameEnd ##0 rs485[p] |=> !lineA_oe[p] && !lineB_oe[p])
      else $error("Driver still enabled after the frame.");
    a_mdrop_ignore: assert property (@(posedge sys_clk) disable iff (rst)
      cmdValid[p] && m[B_MDROP] && !rs485[p] && cmdId[p] != idQ
      |=> !cmdAccept[p] && !cmdReject[p])
      else $error("Multidrop answered a foreign identifier.");
  end

  a_mode_reset: assert property (@(posedge sys_clk)
    rst |=> modeQ[0] == MODE_RST && modeQ[1] == MODE_RST)
    else $error("Mode words wrong after reset.");
endmodule
`default_nettype wire

// >>> src/spm_pkg.sv
// Constants, register map and types for the serial port mode control block.
// Assumes one 125 MHz clock and a synchronous active-high reset.
package spm_pkg;
  localparam int MODE_W = 13;
  localparam int B_QUIET = 0;
  localparam int B_COMPUTER = 1;
  localparam int B_SECURE = 2;
  localparam int B_HWHS = 3;
  localparam int B_PROTO = 4;
  localparam int B_MDROP = 5;
  localparam int B_MODEM = 6;
  localparam int B_ERRFIX = 7;
  localparam int B_XONOFF = 8;
  localparam int B_FIFO = 9;
  localparam int B_RS485 = 10;
  localparam int B_E71 = 11;
  localparam int B_PROMPT = 12;
  localparam logic [MODE_W-1:0] MODE_RST = 13'h0380;
  localparam logic [15:0] ID_RST = 16'h0168;
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam logic [4:0] OFS_MODE0 = 5'h00;
  localparam logic [4:0] OFS_MODE1 = 5'h04;
  localparam logic [4:0] OFS_ID = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0C;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLV = 2'h2;
  localparam logic [3:0] FRAME_BITS = 4'hA;
  localparam int BAUD_DIV_RST = 1085;
  typedef enum logic {TX_IDLE, TX_SHIFT} spm_tx_t;
endpackage

// >>> verif/spm_far_end.sv
// Far-end terminal model: decodes frames on the device's transmit pin and grants CTS.
// Assumes the bench clock and the device's bit period given in clock cycles.
`timescale 1ns/1ps
`default_nettype none
module spm_far_end #(
  parameter int BAUD_DIV = 4
) (
  // Clock.
  input  wire logic       sysClk,
  // Device transmit pin.
  input  wire logic       lineOut,
  input  wire logic       lineEn,
  // Handshake.
  input  wire logic       ctsAllow,
  output logic            ctsLine,
  // Decoded frames.
  output logic [7:0]      rxByte,
  output logic            stopOk,
  output int              frameCount
);
  logic wireLvl;
  // A pin nobody drives rests at mark, so a released driver reads as idle.
  assign wireLvl = lineEn ? lineOut : 1'b1;
  assign ctsLine = ctsAllow;
  initial begin
    frameCount = 0;
    rxByte = 8'h00;
    stopOk = 1'b0;
    forever begin
      @(posedge sysClk);
      if (wireLvl === 1'b0) begin
        repeat (BAUD_DIV / 2) @(posedge sysClk);
        for (int i = 0; i < 8; i++) begin
          repeat (BAUD_DIV) @(posedge sysClk);
          rxByte[i] = wireLvl;
        end
        repeat (BAUD_DIV) @(posedge sysClk);
        stopOk = wireLvl;
        frameCount++;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/test_serial_port_mode_control.sv
// Self-checking bench for the serial port mode control block.
// Assumes the block's package and the far-end model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module test_serial_port_mode_control;
  import spm_pkg::*;
  localparam int BD  = 4;
  localparam int LIM = 200;
  logic sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [4:0]       s_axi_awaddr, s_axi_araddr;
  logic [31:0]      s_axi_wdata, s_axi_rdata, rd, m, seed;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp, rsp, txValid, txUnsol, txEcho, txReady, rxValid;
  logic [1:0]       rxRoom, rxLine, cmdValid, cmdHelp, cmdPass, cmdAccept, cmdReject, lineA_i;
  logic [1:0]       lineA_o, lineA_oe, lineB_i, lineB_o, lineB_oe, rts_o, dsr_o, modemInitReq;
  logic [1:0]       cfgAltProto, cfgParityFix, cfgFifo, cfgPrompt, ctsOk, farA, farB;
  logic [1:0][7:0]  txData, rxData;
  logic [1:0][15:0] cmdId;
  logic             roleDte, boardSel6, terminationStrap, rs485Active, termActive;
  logic             farPin0, farStop, modemSeen;
  logic [7:0]       farByte;
  wire  [1:0]       cts_i;
  int               farCount, err_count, n_compared, base, modemPulses;
  // Pin inputs see the device's own drive when enabled, else the far end's level.
  assign lineA_i = (lineA_oe & lineA_o) | (~lineA_oe & farA);
  assign lineB_i = (lineB_oe & lineB_o) | (~lineB_oe & farB);
  assign cts_i[1] = ctsOk[1];
  spm_serial_port_mode_control #(.BAUD_DIV(BD)) uut (.sys_clk, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txValid, .txData, .txUnsol,
    .txEcho, .txReady, .rxValid, .rxData, .rxRoom, .rxLine, .cmdValid, .cmdHelp, .cmdPass,
    .cmdId, .cmdAccept, .cmdReject, .lineA_i, .lineA_o, .lineA_oe, .lineB_i, .lineB_o,
    .lineB_oe, .cts_i, .rts_o, .dsr_o, .roleDte, .boardSel6, .terminationStrap, .modemInitReq,
    .cfgAltProto, .cfgParityFix, .cfgFifo, .cfgPrompt, .rs485Active, .termActive);
  spm_far_end #(.BAUD_DIV(BD)) farEnd (.sysClk(sys_clk),
    .lineOut(farPin0 ? lineB_o[0] : lineA_o[0]), .lineEn(farPin0 ? lineB_oe[0] : lineA_oe[0]),
    .ctsAllow(ctsOk[0]), .ctsLine(cts_i[0]), .rxByte(farByte), .stopOk(farStop),
    .frameCount(farCount));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // The modem init request is a one-cycle pulse, so it is counted as it happens.
  always @(posedge sys_clk) begin
    if (modemInitReq[1] === 1'b1) modemPulses++;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Seven-bit framing carries even parity where the eighth data bit would be.
  function automatic logic [7:0] expByte(input logic [7:0] d, input logic e71);
    return e71 ? {^d[6:0], d[6:0]} : d;
  endfunction
  task finish_test();
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task tmo(input int n);
    if (n >= LIM) begin
      err_count++;
      $display("wrong value wait cycles expected %0d seen %0d", LIM - 1, n);
      finish_test();
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task axiWrite(input logic [4:0] a, input logic [31:0] d);
    int n;
    logic aw, w;
    tick(1);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    n = 0;
    while (!(aw && w) && n < LIM) begin
      tick(1);
      n++;
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin tick(1); n++; end while (s_axi_bvalid !== 1'b1 && n < LIM);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask
  task axiRead(input logic [4:0] a);
    int n;
    tick(1);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin tick(1); n++; end while (s_axi_arready !== 1'b1 && n < LIM);
    s_axi_arvalid <= 1'b0;
    do begin tick(1); n++; end while (s_axi_rvalid !== 1'b1 && n < LIM);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask
  task sendChar(input int p, input logic [7:0] d, input logic [1:0] kind);
    int n;
    tick(1);
    txValid[p] <= 1'b1;
    txData[p] <= d;
    {txUnsol[p], txEcho[p]} <= kind;
    n = 0;
    do begin tick(1); n++; end while (txReady[p] !== 1'b1 && n < LIM);
    txValid[p] <= 1'b0;
    tmo(n);
  endtask
  task sendCmd(input int p, input logic [1:0] hp, input logic [15:0] id);
    tick(1);
    cmdValid[p] <= 1'b1;
    {cmdHelp[p], cmdPass[p]} <= hp;
    cmdId[p] <= id;
    tick(1);
    cmdValid[p] <= 1'b0;
    tick(1);
    rsp = {cmdAccept[p], cmdReject[p]};
  endtask
  initial begin
    seed = 32'h00000054;
    err_count = 0;
    n_compared = 0;
    modemPulses = 0;
    modemSeen = 1'b0;
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, txValid, txUnsol, txEcho, txData} = '0;
    {rxValid, rxData, cmdValid, cmdHelp, cmdPass, cmdId, roleDte, boardSel6} = '0;
    {terminationStrap, farPin0} = '0;
    {rxRoom, ctsOk, farA, farB, s_axi_wstrb} = 12'hFFF;
    tick(6);
    rst <= 1'b0;
    tick(4);
    axiRead(OFS_MODE0);
    `CHK("mode0 reset", 32'(MODE_RST), rd)
    axiRead(OFS_ID);
    `CHK("id reset", 32'(ID_RST), rd)
    `CHK("dce pins", 2'b01, {lineB_oe[0], lineA_oe[0]})
    `CHK("rs232 default", 1'b0, rs485Active)
    axiRead(5'h10);
    `CHK("unmapped resp", RESP_SLV, rsp)
    `CHK("unmapped data", 32'h00000000, rd)
    axiWrite(OFS_STATUS, 32'h000000FF);
    `CHK("status write", RESP_SLV, rsp)
    for (int i = 0; i < 4; i++) begin
      m = rnd();
      rxRoom <= m[31:30];
      m[31:13] = '0;
      modemSeen = modemSeen | m[B_MODEM];
      axiWrite(OFS_MODE1, m);
      `CHK("write resp", RESP_OK, rsp)
      axiRead(OFS_MODE1);
      `CHK("mode1", m, rd)
      axiRead(OFS_MODE0);
      `CHK("mode0 kept", 32'(MODE_RST), rd)
      `CHK("alt proto", m[B_PROTO], cfgAltProto[1])
      `CHK("parity fix", m[B_ERRFIX], cfgParityFix[1])
      `CHK("fifo", m[B_FIFO], cfgFifo[1])
      `CHK("prompt", m[B_PROMPT], cfgPrompt[1])
      `CHK("modem lines", m[B_MODEM], dsr_o[1])
      if (m[B_HWHS]) `CHK("rts", rxRoom[1], rts_o[1])
    end
    `CHK("modem init", modemSeen ? 1 : 0, modemPulses)
    axiWrite(OFS_MODE0, 32'h00000000);
    for (int e = 0; e < 2; e++) begin
      m = rnd();
      base = farCount;
      sendChar(0, m[7:0], 2'b00);
      tick(11 * BD + 6);
      `CHK("frame count", base + 1, farCount)
      `CHK("frame byte", expByte(m[7:0], e[0]), farByte)
      `CHK("stop bit", 1'b1, farStop)
      axiWrite(OFS_MODE0, 32'h00000800);
    end
    axiWrite(OFS_MODE0, 32'h0000000B);
    base = farCount;
    for (int k = 0; k < 3; k++) begin
      sendChar(0, 8'h5A, 2'b10 >> k);
      tick(11 * BD + 6);
    end
    `CHK("suppressed", base + 1, farCount)
    `CHK("requested", 8'h5A, farByte)
    ctsOk[0] <= 1'b0;
    rxRoom[0] <= 1'b0;
    tick(6);
    `CHK("cts stall", 1'b0, txReady[0])
    `CHK("rts full", 1'b0, rts_o[0])
    ctsOk[0] <= 1'b1;
    rxRoom[0] <= 1'b1;
    tick(6);
    `CHK("cts go", 1'b1, txReady[0])
    `CHK("rts room", 1'b1, rts_o[0])
    axiWrite(OFS_MODE0, 32'h00000100);
    for (int k = 0; k < 2; k++) begin
      tick(1);
      rxValid[0] <= 1'b1;
      rxData[0] <= k ? CH_XON : CH_XOFF;
      tick(1);
      rxValid[0] <= 1'b0;
      tick(4);
      `CHK("flow ready", k[0], txReady[0])
    end
    roleDte <= 1'b1;
    farA <= 2'b10;
    farPin0 <= 1'b1;
    tick(8);
    `CHK("dte pins", 2'b10, {lineB_oe[0], lineA_oe[0]})
    `CHK("dte receive", 1'b0, rxLine[0])
    sendChar(0, 8'hC3, 2'b00);
    tick(11 * BD + 6);
    `CHK("dte byte", 8'hC3, farByte)
    roleDte <= 1'b0;
    farPin0 <= 1'b0;
    farA <= 2'b11;
    farB <= 2'b10;
    tick(8);
    `CHK("dce receive", 1'b0, rxLine[0])
    axiWrite(OFS_MODE0, 32'h00000004);
    for (int k = 0; k < 4; k++) begin
      sendCmd(0, (k == 1) ? 2'b10 : (k == 2) ? 2'b01 : 2'b00, ID_RST);
      `CHK("secure cmd", (k == 0) ? 2'b01 : 2'b10, rsp)
    end
    axiWrite(OFS_MODE0, 32'h00000020);
    sendCmd(0, 2'b00, ID_RST);
    `CHK("own id", 2'b10, rsp)
    sendCmd(0, 2'b00, ~ID_RST);
    `CHK("other id", 2'b00, rsp)
    boardSel6 <= 1'b1;
    terminationStrap <= 1'b1;
    axiWrite(OFS_MODE1, 32'h00000420);
    tick(6);
    `CHK("terminated", 2'b11, {rs485Active, termActive})
    axiRead(OFS_STATUS);
    `CHK("status", 32'h0000004E, rd)
    sendCmd(1, 2'b00, ~ID_RST);
    `CHK("485 over mdrop", 2'b10, rsp)
    `CHK("485 idle", 1'b0, lineA_oe[1] | lineB_oe[1])
    sendChar(1, 8'h96, 2'b00);
    tick(2 * BD);
    `CHK("485 drive", 1'b1, lineA_oe[1] | lineB_oe[1])
    `CHK("485 pair", 2'b10, {lineA_o[1], lineB_o[1]})
    tick(10 * BD + 6);
    `CHK("485 release", 1'b0, lineA_oe[1] | lineB_oe[1])
    terminationStrap <= 1'b0;
    tick(6);
    `CHK("unterminated", 2'b10, {rs485Active, termActive})
    boardSel6 <= 1'b0;
    tick(6);
    `CHK("rs232 again", 1'b0, rs485Active)
    finish_test();
  end
endmodule
`default_nettype wire
